// ==== ism_pkg.sv ====
package ism_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_TX = 8'h0c;
  localparam logic [7:0] OFS_RX = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;

  // status flag positions
  localparam int B_ACK = 15;
  localparam int B_TRS = 14;
  localparam int B_COLL = 10;
  localparam int B_GC = 9;
  localparam int B_TEN = 8;
  localparam int B_WCOL = 7;
  localparam int B_OV = 6;
  localparam int B_DA = 5;
  localparam int B_STOP = 4;
  localparam int B_START = 3;
  localparam int B_RW = 2;
  localparam int B_RXF = 1;
  localparam int B_TXF = 0;
  // flags software may clear by writing zero
  localparam logic [15:0] STAT_W0C = 16'h04d8;

  // own config register fields
  localparam int CFG_MODE = 10;
  localparam int CFG_GCE = 11;

  // interrupt status bits
  localparam int IRQ_W = 5;
  localparam int IRQ_RX = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_COLL = 3;
  localparam int IRQ_GC = 4;

  // reset values and address constants
  localparam logic [9:0] MASK_RST = 10'h000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] TEN_HDR = 5'h1e;
  localparam logic [7:0] GC_ADDR = 8'h00;

  // true for every mapped register offset
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == OFS_STATUS) || (a == OFS_MASK) ||
      (a == OFS_CFG) || (a == OFS_TX) || (a == OFS_RX) ||
      (a == OFS_IRQ_ST) || (a == OFS_IRQ_EN);
  endfunction
endpackage

// ==== ism_apb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ism_apb
  import ism_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [15:0] rd_data,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ism_apb_t;

  ism_apb_t s;
  ism_apb_t next_s;

  // no wait state: answer is prepared during the setup cycle
  always_comb begin
    next_s = s;
    if (psel && !penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !reg_known(paddr);
      next_s.prdata = pwrite ? 32'h0000_0000 : {16'h0000, rd_data};
    end else if (s.pready) begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
endmodule
`default_nettype wire

// ==== ism_addr_match.sv ====
`timescale 1ns/1ps
`default_nettype none
module ism_addr_match
  import ism_pkg::*;
(
  input wire logic [7:0] rx_byte,
  input wire logic [9:0] own_slave_address,
  input wire logic [9:0] addr_bit_mask,
  input wire logic ten_bit_addr_mode,
  input wire logic general_call_enable,
  output logic gc_hit,
  output logic hit7,
  output logic hdr_hit,
  output logic low_hit
);
  // a one in the mask waives the match in that position
  function automatic logic masked_eq(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic [7:0] m);
    masked_eq = &(~(a ^ b) | m);
  endfunction

  // seven-bit mode only looks at the low seven mask bits
  always_comb begin
    gc_hit = general_call_enable && (rx_byte == GC_ADDR);
    hit7 = !ten_bit_addr_mode &&
      masked_eq({1'b0, rx_byte[7:1]}, {1'b0, own_slave_address[6:0]},
                {1'b0, addr_bit_mask[6:0]});
    hdr_hit = ten_bit_addr_mode && (rx_byte[7:3] == TEN_HDR) &&
      masked_eq({6'h00, rx_byte[2:1]}, {6'h00, own_slave_address[9:8]},
                {6'h00, addr_bit_mask[9:8]});
    low_hit = masked_eq(rx_byte, own_slave_address[7:0],
                        addr_bit_mask[7:0]);
  end
endmodule
`default_nettype wire

// ==== ism_status_mask.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - master transmit end of ack sets flag on nack, clears on ack.
// - master transmit flag rises at start, falls when slave ack ends.
// - collision flag set on master collision, software clears it by zero.
// - general call flag set on general call address, cleared on stop.
// - ten-bit match flag set on second address byte match, cleared on stop.
// - transmit write while busy is dropped and sets write collision.
// - byte arriving while receive buffer full sets overflow flag.
// - data/address flag cleared on address match, set on data byte.
// - start and stop flags show only the latest bus condition.
// - direction flag taken from own or general call address byte, one means read.
// - receive-full set on buffer load, cleared when software reads it.
// - transmit-full set on software write, cleared when byte is sent.
// - mask bit one waives that address bit, zero needs exact match.
// - completed byte moves to receive buffer with an interrupt pulse.
// - general call recognised only while general call enable is one.
// - mode bit picks ten-bit or seven-bit own address compare.
module ism_status_mask
  import ism_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_start,
  input wire logic bus_stop,
  input wire logic mst_tx_begin,
  input wire logic ack_end,
  input wire logic ack_nack,
  input wire logic bus_collision,
  input wire logic tx_done,
  input wire logic tx_busy,
  input wire logic addr1_rx,
  input wire logic addr2_rx,
  input wire logic data_rx,
  input wire logic [7:0] rx_byte,
  output logic [7:0] tx_byte,
  output logic tx_load,
  output logic rx_pulse,
  output logic slave_match,
  output logic irq
);
  typedef struct packed {
    logic ack_result_flag;
    logic master_tx_active;
    logic collision_flag;
    logic general_call_seen;
    logic ten_bit_match;
    logic write_collision;
    logic rx_overflow;
    logic data_not_addr;
    logic stop_seen;
    logic start_seen;
    logic read_not_write;
    logic rx_buffer_full;
    logic tx_buffer_full;
    logic hdr_ok;
    logic [9:0] addr_bit_mask;
    logic [9:0] own_slave_address;
    logic ten_bit_addr_mode;
    logic general_call_enable;
    logic [7:0] rx_holding_reg;
    logic [7:0] tx_holding_reg;
    logic tx_load;
    logic rx_pulse;
    logic slave_match;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } ism_state_t;

  ism_state_t s;
  ism_state_t next_s;
  logic [15:0] status_word;
  logic [15:0] rd_data;
  logic wr_go;
  logic rd_go;
  logic gc_hit;
  logic hit7;
  logic hdr_hit;
  logic low_hit;
  logic [IRQ_W-1:0] irq_set;

  ism_apb u_apb (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rd_data(rd_data),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  ism_addr_match u_match (
    .rx_byte(rx_byte),
    .own_slave_address(s.own_slave_address),
    .addr_bit_mask(s.addr_bit_mask),
    .ten_bit_addr_mode(s.ten_bit_addr_mode),
    .general_call_enable(s.general_call_enable),
    .gc_hit(gc_hit),
    .hit7(hit7),
    .hdr_hit(hdr_hit),
    .low_hit(low_hit)
  );

  // transfer completes on the edge that sees pready with the access
  assign wr_go = ce && psel && penable && pready && pwrite;
  assign rd_go = ce && psel && penable && pready && !pwrite;

  // status image; bits 13..11 are unimplemented and stay zero
  always_comb begin
    status_word = 16'h0000;
    status_word[B_ACK] = s.ack_result_flag;
    status_word[B_TRS] = s.master_tx_active;
    status_word[B_COLL] = s.collision_flag;
    status_word[B_GC] = s.general_call_seen;
    status_word[B_TEN] = s.ten_bit_match;
    status_word[B_WCOL] = s.write_collision;
    status_word[B_OV] = s.rx_overflow;
    status_word[B_DA] = s.data_not_addr;
    status_word[B_STOP] = s.stop_seen;
    status_word[B_START] = s.start_seen;
    status_word[B_RW] = s.read_not_write;
    status_word[B_RXF] = s.rx_buffer_full;
    status_word[B_TXF] = s.tx_buffer_full;
  end

  // read mux, sampled by the slave during the setup cycle
  always_comb begin
    rd_data = 16'h0000;
    unique case (paddr)
      OFS_STATUS: rd_data = status_word;
      OFS_MASK: rd_data = {6'h00, s.addr_bit_mask};
      OFS_CFG: rd_data = {4'h0, s.general_call_enable,
                          s.ten_bit_addr_mode, s.own_slave_address};
      OFS_RX: rd_data = {8'h00, s.rx_holding_reg};
      OFS_IRQ_ST: rd_data = {11'h000, s.irq_status};
      OFS_IRQ_EN: rd_data = {11'h000, s.irq_mask};
      default: rd_data = 16'h0000;
    endcase
  end

  // software accesses first, bus events after: a hardware set
  // in the same cycle as a software clear wins
  always_comb begin
    next_s = s;
    next_s.tx_load = 1'b0;
    next_s.rx_pulse = 1'b0;
    next_s.slave_match = 1'b0;
    irq_set = IRQ_RST;

    if (wr_go) begin
      unique case (paddr)
        OFS_STATUS: begin
          // only the clear-only flags react, and only to zeros
          if (STAT_W0C[B_COLL] && !pwdata[B_COLL])
            next_s.collision_flag = 1'b0;
          if (STAT_W0C[B_WCOL] && !pwdata[B_WCOL])
            next_s.write_collision = 1'b0;
          if (STAT_W0C[B_OV] && !pwdata[B_OV])
            next_s.rx_overflow = 1'b0;
          if (STAT_W0C[B_STOP] && !pwdata[B_STOP])
            next_s.stop_seen = 1'b0;
          if (STAT_W0C[B_START] && !pwdata[B_START])
            next_s.start_seen = 1'b0;
        end
        OFS_MASK: next_s.addr_bit_mask = pwdata[9:0];
        OFS_CFG: begin
          next_s.own_slave_address = pwdata[9:0];
          next_s.ten_bit_addr_mode = pwdata[CFG_MODE];
          next_s.general_call_enable = pwdata[CFG_GCE];
        end
        OFS_TX: begin
          if (tx_busy) begin
            next_s.write_collision = 1'b1;
          end else begin
            next_s.tx_holding_reg = pwdata[7:0];
            next_s.tx_buffer_full = 1'b1;
            next_s.tx_load = 1'b1;
          end
        end
        OFS_IRQ_ST: next_s.irq_status = s.irq_status & ~pwdata[IRQ_W-1:0];
        OFS_IRQ_EN: next_s.irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // reading the receive buffer empties it
    if (rd_go && (paddr == OFS_RX))
      next_s.rx_buffer_full = 1'b0;

    // bus conditions: only the latest kind reads as one
    if (bus_start) begin
      next_s.start_seen = 1'b1;
      next_s.stop_seen = 1'b0;
    end
    if (bus_stop) begin
      next_s.stop_seen = 1'b1;
      next_s.start_seen = 1'b0;
      next_s.general_call_seen = 1'b0;
      next_s.ten_bit_match = 1'b0;
      next_s.hdr_ok = 1'b0;
      irq_set[IRQ_STOP] = 1'b1;
    end

    // master transmit progress and the slave's answer
    if (mst_tx_begin)
      next_s.master_tx_active = 1'b1;
    if (ack_end) begin
      next_s.ack_result_flag = ack_nack;
      next_s.master_tx_active = 1'b0;
    end
    if (bus_collision) begin
      next_s.collision_flag = 1'b1;
      irq_set[IRQ_COLL] = 1'b1;
    end
    // a byte accepted in this very cycle keeps the buffer full
    if (tx_done && !next_s.tx_load)
      next_s.tx_buffer_full = 1'b0;

    // first address byte: general call, 7-bit or 10-bit header
    if (addr1_rx) begin
      if (gc_hit) begin
        next_s.general_call_seen = 1'b1;
        next_s.data_not_addr = 1'b0;
        next_s.read_not_write = rx_byte[0];
        irq_set[IRQ_GC] = 1'b1;
      end else if (hit7) begin
        next_s.data_not_addr = 1'b0;
        next_s.read_not_write = rx_byte[0];
        next_s.slave_match = 1'b1;
        irq_set[IRQ_MATCH] = 1'b1;
      end else if (hdr_hit) begin
        // a read header after a matched pair addresses us again
        next_s.hdr_ok = 1'b1;
        next_s.read_not_write = rx_byte[0];
        if (s.ten_bit_match && rx_byte[0]) begin
          next_s.data_not_addr = 1'b0;
          next_s.slave_match = 1'b1;
          irq_set[IRQ_MATCH] = 1'b1;
        end
      end else begin
        next_s.hdr_ok = 1'b0;
      end
    end

    // second byte of a 10-bit address
    if (addr2_rx && s.hdr_ok && low_hit) begin
      next_s.ten_bit_match = 1'b1;
      next_s.data_not_addr = 1'b0;
      next_s.slave_match = 1'b1;
      irq_set[IRQ_MATCH] = 1'b1;
    end

    // data byte: double-buffered receive, old byte kept on overflow
    if (data_rx) begin
      next_s.data_not_addr = 1'b1;
      if (s.rx_buffer_full && !(rd_go && (paddr == OFS_RX))) begin
        next_s.rx_overflow = 1'b1;
      end else begin
        next_s.rx_holding_reg = rx_byte;
        next_s.rx_buffer_full = 1'b1;
        next_s.rx_pulse = 1'b1;
        irq_set[IRQ_RX] = 1'b1;
      end
    end

    // sticky events and the gated level output
    next_s.irq_status = next_s.irq_status | irq_set;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  // reset gives all-zero flags, mask and config
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign tx_byte = s.tx_holding_reg;
  assign tx_load = s.tx_load;
  assign rx_pulse = s.rx_pulse;
  assign slave_match = s.slave_match;
  assign irq = s.irq;
endmodule
`default_nettype wire

// ==== ism_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module ism_far_end (
  input wire logic mclk,
  input wire logic [3:0] cmd,
  input wire logic [7:0] cbyte,
  output logic bus_start,
  output logic bus_stop,
  output logic mst_tx_begin,
  output logic ack_end,
  output logic ack_nack,
  output logic bus_collision,
  output logic tx_done,
  output logic addr1_rx,
  output logic addr2_rx,
  output logic data_rx,
  output logic [7:0] rx_byte
);
  logic [7:0] last = 8'h00;
  // one bus event per command cycle, code 0 is idle
  assign bus_start = cmd == 4'h1;
  assign bus_stop = cmd == 4'h2;
  assign mst_tx_begin = cmd == 4'h3;
  assign ack_end = cmd == 4'h4 || cmd == 4'h5;
  assign ack_nack = cmd == 4'h5;
  assign bus_collision = cmd == 4'h6;
  assign tx_done = cmd == 4'h7;
  assign addr1_rx = cmd == 4'h8;
  assign addr2_rx = cmd == 4'h9;
  assign data_rx = cmd == 4'ha;
  // byte lines toggle outside a byte event, so stale sampling shows
  assign rx_byte = (cmd >= 4'h8) ? cbyte : ~last;
  always_ff @(posedge mclk) begin
    last <= rx_byte;
  end
endmodule
`default_nettype wire

// ==== ism_status_mask_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ism_sm_asserts
  import ism_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_busy,
  input wire logic addr1_rx,
  input wire logic addr2_rx,
  input wire logic data_rx,
  input wire logic [7:0] tx_byte,
  input wire logic tx_load,
  input wire logic rx_pulse,
  input wire logic slave_match
);
  logic rd_rx;
  logic rx_held;
  logic rx_full_h;

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // shadow of the receive-full flag, rebuilt from pulses and reads
  assign rd_rx = ce && psel && penable && pready && !pwrite &&
    paddr == OFS_RX;
  assign rx_held = rx_full_h || rx_pulse;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_full_h <= 1'b0;
    end else if (ce) begin
      rx_full_h <= rx_held && !rd_rx;
    end
  end
  // setup phase, then the completing access edge of a transmit write
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_wr_tx;
    psel && penable && pready && pwrite && ce && paddr == OFS_TX;
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready && psel)
    else $error("error without ready");
  AST_RD_UPPER: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_TX_TAKE: assert property (s_wr_tx ##0 !tx_busy |=> tx_load)
    else $error("transmit write not taken");
  AST_TX_BYTE: assert property (tx_load |->
    {24'h000000, tx_byte} == ($past(pwdata) & 32'h0000_00ff))
    else $error("wrong transmit byte");
  AST_TX_BUSY: assert property (s_wr_tx ##0 tx_busy |=> !tx_load)
    else $error("write taken while busy");
  AST_RX_MOVE: assert property (data_rx && ce &&
    !(rx_held && !rd_rx) |=> rx_pulse)
    else $error("no receive pulse");
  AST_RX_KEEP: assert property (data_rx && ce &&
    rx_held && !rd_rx |=> !rx_pulse)
    else $error("full buffer overwritten");
  AST_MATCH_CAUSE: assert property (slave_match |->
    $past(addr1_rx) || $past(addr2_rx))
    else $error("match without address byte");
endmodule
bind ism_status_mask ism_sm_asserts u_chk (.mclk, .arst_n, .ce, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_busy,
  .addr1_rx, .addr2_rx, .data_rx, .tx_byte, .tx_load, .rx_pulse,
  .slave_match);
`default_nettype wire

// ==== ism_status_mask_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ism_status_mask_tb;
  import ism_pkg::*;
  logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic tx_busy = 0, err, hit, pready, pslverr, tx_load, rx_pulse;
  logic slave_match, irq, bus_start, bus_stop, mst_tx_begin, ack_end;
  logic ack_nack, bus_collision, tx_done, addr1_rx, addr2_rx, data_rx;
  logic [7:0] paddr = 8'h00, cbyte = 8'h00, rx_byte, tx_byte;
  logic [3:0] cmd = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int mismatches = 0, checked = 0, cycles = 0;

  initial forever #12.5 mclk = ~mclk;

  ism_status_mask u_dut (.mclk, .arst_n, .ce(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_start,
    .bus_stop, .mst_tx_begin, .ack_end, .ack_nack, .bus_collision,
    .tx_done, .tx_busy, .addr1_rx, .addr2_rx, .data_rx, .rx_byte,
    .tx_byte, .tx_load, .rx_pulse, .slave_match, .irq);
  ism_far_end u_far (.mclk, .cmd, .cbyte, .bus_start, .bus_stop,
    .mst_tx_begin, .ack_end, .ack_nack, .bus_collision, .tx_done,
    .addr1_rx, .addr2_rx, .data_rx, .rx_byte);

  task conclude;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for ready rather than assuming a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task sb(input int pos, input logic v);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[pos]}, {31'h0, v});
  endtask

  // single-cycle event from the far side, match pulse sampled after
  task ev(input logic [3:0] c, input logic [7:0] b);
    @(posedge mclk);
    cmd <= c;
    cbyte <= b;
    @(posedge mclk);
    cmd <= 4'h0;
    #1 hit = slave_match;
  endtask

  task t_regs;
    rchk(OFS_STATUS, 32'h0);
    rchk(OFS_MASK, 32'h0);
    apb(1'b1, OFS_MASK, 32'hffff_ffff);
    rchk(OFS_MASK, 32'h3ff);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task t_bus;
    ev(4'h1, 8'h0);
    sb(B_START, 1'b1);
    sb(B_STOP, 1'b0);
    ev(4'h2, 8'h0);
    sb(B_STOP, 1'b1);
    sb(B_START, 1'b0);
    ev(4'h3, 8'h0);
    sb(B_TRS, 1'b1);
    ev(4'h5, 8'h0);
    sb(B_TRS, 1'b0);
    sb(B_ACK, 1'b1);
    ev(4'h4, 8'h0);
    sb(B_ACK, 1'b0);
    ev(4'h6, 8'h0);
    apb(1'b1, OFS_STATUS, 32'hffff);
    sb(B_COLL, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h0);
    sb(B_COLL, 1'b0);
  endtask

  task t_tx;
    apb(1'b1, OFS_TX, 32'h5a);
    sb(B_TXF, 1'b1);
    chk({24'h0, tx_byte}, 32'h5a);
    ev(4'h7, 8'h0);
    sb(B_TXF, 1'b0);
    tx_busy <= 1'b1;
    apb(1'b1, OFS_TX, 32'h33);
    sb(B_WCOL, 1'b1);
    sb(B_TXF, 1'b0);
    chk({24'h0, tx_byte}, 32'h5a);
    tx_busy <= 1'b0;
    apb(1'b1, OFS_STATUS, 32'h0);
    sb(B_WCOL, 1'b0);
  endtask

  task t_rx;
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    ev(4'ha, 8'h11);
    sb(B_RXF, 1'b1);
    sb(B_DA, 1'b1);
    chk({31'h0, irq}, 32'h1);
    ev(4'ha, 8'h22);
    sb(B_OV, 1'b1);
    rchk(OFS_RX, 32'h11);
    sb(B_RXF, 1'b0);
    apb(1'b1, OFS_IRQ_ST, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    ev(4'ha, 8'h33);
    apb(1'b1, OFS_STATUS, 32'h0);
    sb(B_OV, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rchk(OFS_RX, 32'h33);
  endtask

  task t_addr;
    apb(1'b1, OFS_MASK, 32'h0);
    apb(1'b1, OFS_CFG, 32'h2a);
    ev(4'h8, 8'h55);
    chk({31'h0, hit}, 32'h1);
    sb(B_RW, 1'b1);
    sb(B_DA, 1'b0);
    ev(4'h8, 8'h56);
    chk({31'h0, hit}, 32'h0);
    apb(1'b1, OFS_MASK, 32'h1);
    ev(4'h8, 8'h56);
    chk({31'h0, hit}, 32'h1);
    sb(B_RW, 1'b0);
    // upper mask bits must not waive anything in seven-bit mode
    apb(1'b1, OFS_MASK, 32'h380);
    ev(4'h8, 8'h56);
    chk({31'h0, hit}, 32'h0);
    ev(4'h8, 8'h00);
    sb(B_GC, 1'b0);
    apb(1'b1, OFS_CFG, 32'h82a);
    ev(4'h8, 8'h00);
    sb(B_GC, 1'b1);
    ev(4'h2, 8'h0);
    sb(B_GC, 1'b0);
    apb(1'b1, OFS_MASK, 32'h0);
    apb(1'b1, OFS_CFG, 32'h6a5);
    ev(4'h8, 8'hf4);
    ev(4'h9, 8'ha5);
    sb(B_TEN, 1'b1);
    ev(4'h8, 8'hf5);
    chk({31'h0, hit}, 32'h1);
    sb(B_RW, 1'b1);
    ev(4'h2, 8'h0);
    sb(B_TEN, 1'b0);
  endtask

  // run is a few hundred cycles, so this ceiling only catches a hang
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude;
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs;
    t_bus;
    t_tx;
    t_rx;
    t_addr;
    conclude;
  end
endmodule
`default_nettype wire
